// file: sa_pkg.sv
// Purpose: Shared constants and types for the alarm I/O and capture block
// Assumes: One clock; event bits 0..2 come from neighbouring on-chip logic
// Notes: Capture events map onto consecutive alarm triggers 14..26
package sa_pkg;

  localparam int NUM_INPUTS = 61;
  localparam int NUM_INTERNAL = 3;
  localparam int NUM_EVENTS = 64;
  localparam int HALF_EVENTS = 32;
  localparam int NUM_ACTIONS = 8;
  localparam int ACT_IDX_W = 3;
  localparam int EVT_IDX_W = 6;
  localparam int NUM_COUNTERS = 4;
  localparam int COUNT_W = 8;
  localparam int TIMER_W = 32;
  localparam int SYNC_STAGES = 2;

  localparam int COLD_RESET_ACTION = 0;
  localparam int WARM_RESET_ACTION = 1;

  // Capture events: 0 lockstep, 1..3 error records, 4 parity write,
  // 5..8 single-bit ECC groups, 9..12 double-bit ECC groups.
  localparam int NUM_CAP_EVENTS = 13;
  localparam int CAP_TRIG_BASE = 14;
  localparam int CAP_WORDS = 16;
  localparam int CAP_W = 32;
  localparam int CAP_PARITY_EVT = 4;
  localparam int CAP_PARITY_FIRST_WORD = 4;
  localparam int CAP_PARITY_LAST_WORD = 7;
  localparam int CAP_ECC_WORD_SHIFT = 3;

  localparam logic [COUNT_W-1:0] COUNT_MAX = 8'hFF;
  localparam logic [TIMER_W-1:0] TIMER_ZERO = 32'h0000_0000;
  localparam logic [TIMER_W-1:0] TIMER_STEP = 32'h0000_0001;

  typedef enum logic [1:0] {
    SA_CFG_WAIT = 2'b00,
    SA_CFG_REQ = 2'b01,
    SA_CFG_DONE = 2'b11
  } sa_cfg_state_e;

  // Which capture event loads a given 32-bit capture word
  function automatic int sa_cap_word_event(input int word);
    if (word < CAP_PARITY_FIRST_WORD)
      return word;
    else if (word <= CAP_PARITY_LAST_WORD)
      return CAP_PARITY_EVT;
    else
      return word - CAP_ECC_WORD_SHIFT;
  endfunction : sa_cap_word_event

endpackage : sa_pkg

// file: sa_sync.sv
// Purpose: Two-flop synchroniser for a vector of independent levels
// Assumes: Each bit is a slow level or a pulse of two clocks or more
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
module sa_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      stage1 <= '0;
      syncOut <= '0;
    end
    else
    begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule : sa_sync

// file: sa_alarm_io.sv
// Purpose: Alarm inputs, status and response outputs, event counters,
//   counter timer, configuration-done trigger and error capture
// Assumes: rst is the power-on reset; cold_reset_n_a is synchronous to clock
// Notes: Configuration arrives on plain ports from the programming logic
`timescale 1ns/1ps

// What this block does
// - Timer expiry clears all counters and reconnects their events directly.
// - Software-supplied initial value sets the counter timer duration.
// - Sixty-one separate alarm inputs, one per attack sensor.
// - Level alarms stay high until software acknowledges the sensor.
// - Sixty-four status outputs show events that reported alarms.
// - Eight response outputs, each requesting one system response.
// - Config-done trigger only after programming and sensors stable.
// - Power-on reset clears syndrome and all capture registers.
// - Cold reset leaves syndrome and capture registers untouched.
// - Action zero requests cold reset, action one warm reset.
// - Programming access is never filtered by security or privilege.
// - Capture event latches its data and raises its alarm event.
// - Captures map to triggers 14, 15-17, 18, 19+n, 23+n.
// - Single clock; alarm pins are synchronised before use.
// - Counted events propagate only after exceeding the programmed count.
// - Cold reset clears hidden status, keeps visible syndrome bits.
module sa_alarm_io (
  input wire logic clock,
  input wire logic rst,
  input wire logic cold_reset_n_a,
  input wire logic [sa_pkg::NUM_INPUTS-1:0] alarmIn,
  input wire logic [sa_pkg::NUM_INTERNAL-1:0] internalEvent,
  input wire logic externalSensorsStable,
  input wire logic configProgrammed,
  input wire logic [sa_pkg::NUM_EVENTS-1:0] syndromeClear,
  input wire logic [sa_pkg::NUM_EVENTS-1:0] routeEnable,
  input wire logic [sa_pkg::NUM_EVENTS*sa_pkg::ACT_IDX_W-1:0] routeAction,
  input wire logic [sa_pkg::TIMER_W-1:0] counterTimerInitialValue,
  input wire logic counterTimerLoad,
  input wire logic [sa_pkg::NUM_COUNTERS-1:0] counterEnable,
  input wire logic [sa_pkg::NUM_COUNTERS*sa_pkg::EVT_IDX_W-1:0]
    counterEventSel,
  input wire logic [sa_pkg::NUM_COUNTERS*sa_pkg::COUNT_W-1:0] counterLimit,
  input wire logic [sa_pkg::NUM_CAP_EVENTS-1:0] captureEvent,
  input wire logic [sa_pkg::CAP_WORDS*sa_pkg::CAP_W-1:0] captureData,
  input wire logic configDoneAck,
  output logic [sa_pkg::NUM_EVENTS-1:0] alarmStatus,
  output logic [sa_pkg::HALF_EVENTS-1:0] eventSyndromeLow,
  output logic [sa_pkg::HALF_EVENTS-1:0] eventSyndromeHigh,
  output logic [sa_pkg::NUM_ACTIONS-1:0] responseAction,
  output logic coldResetRequest,
  output logic warmResetRequest,
  output logic configDoneTrigger,
  output logic [sa_pkg::CAP_WORDS*sa_pkg::CAP_W-1:0] captureReg,
  output logic [sa_pkg::TIMER_W-1:0] counterTimerValue,
  output logic counterTimerExpired
);

  logic coldRst;
  logic [sa_pkg::NUM_INPUTS-1:0] alarmSync;
  logic sensorsStableSync;
  logic [sa_pkg::NUM_EVENTS-1:0] rawEvent;
  logic [sa_pkg::NUM_EVENTS-1:0] prevEvent;
  logic [sa_pkg::NUM_EVENTS-1:0] eventRise;
  logic [sa_pkg::NUM_EVENTS-1:0] eventGate;
  logic [sa_pkg::NUM_EVENTS-1:0] gatedEvent;
  logic [sa_pkg::NUM_EVENTS-1:0] eventStatus;
  logic [sa_pkg::NUM_EVENTS-1:0] syndrome;
  logic [sa_pkg::NUM_ACTIONS-1:0] next_responseAction;
  logic timerRunning;
  logic countersReleased;
  logic [sa_pkg::COUNT_W-1:0] eventCount [sa_pkg::NUM_COUNTERS];
  sa_pkg::sa_cfg_state_e cfgState;

  assign coldRst = !cold_reset_n_a;

  // Sensor pins and the stable flag cross into the clock domain here
  sa_sync #(
    .WIDTH(sa_pkg::NUM_INPUTS + 1)
  ) u_pinSync (
    .clock(clock),
    .rst(rst),
    .asyncIn({externalSensorsStable, alarmIn}),
    .syncOut({sensorsStableSync, alarmSync})
  );

  // Pins fill the bits above the on-chip events; captures OR onto 14..26
  always_comb
  begin
    rawEvent = {alarmSync, internalEvent};
    for (int k = 0; k < sa_pkg::NUM_CAP_EVENTS; k++)
    begin
      rawEvent[sa_pkg::CAP_TRIG_BASE + k] =
        rawEvent[sa_pkg::CAP_TRIG_BASE + k] | captureEvent[k];
    end
  end

  // Pulse and level both read as a sampled level; edges feed the counters
  always_ff @(posedge clock)
  begin
    if (rst || coldRst)
      prevEvent <= '0;
    else
      prevEvent <= rawEvent;
  end

  assign eventRise = rawEvent & ~prevEvent;

  // Counter timer; no attribute filtering, every load is taken as given
  always_ff @(posedge clock)
  begin
    if (rst || coldRst)
    begin
      counterTimerValue <= sa_pkg::TIMER_ZERO;
      timerRunning <= 1'b0;
      counterTimerExpired <= 1'b0;
    end
    else if (counterTimerLoad)
    begin
      counterTimerValue <= counterTimerInitialValue;
      timerRunning <= 1'b1;
      counterTimerExpired <= 1'b0;
    end
    else if (timerRunning)
    begin
      if (counterTimerValue == sa_pkg::TIMER_ZERO)
      begin
        timerRunning <= 1'b0;
        counterTimerExpired <= 1'b1;
      end
      else
      begin
        counterTimerValue <= counterTimerValue - sa_pkg::TIMER_STEP;
        counterTimerExpired <= 1'b0;
      end
    end
    else
      counterTimerExpired <= 1'b0;
  end

  // Once released, counters stay detached until a new timer load
  always_ff @(posedge clock)
  begin
    if (rst || coldRst || counterTimerLoad)
      countersReleased <= 1'b0;
    else if (counterTimerExpired)
      countersReleased <= 1'b1;
  end

  // Event counters, saturating so a noisy sensor cannot wrap back to gated
  for (genvar c = 0; c < sa_pkg::NUM_COUNTERS; c++)
  begin : g_counter
    logic [sa_pkg::EVT_IDX_W-1:0] sel;
    assign sel = counterEventSel[c*sa_pkg::EVT_IDX_W +: sa_pkg::EVT_IDX_W];
    always_ff @(posedge clock)
    begin
      if (rst || coldRst || counterTimerExpired || countersReleased)
        eventCount[c] <= '0;
      else if (counterEnable[c] && eventRise[sel]
               && eventCount[c] != sa_pkg::COUNT_MAX)
        eventCount[c] <= eventCount[c] + 1'b1;
    end
  end

  // The occurrence that takes the count past its limit is the first to pass
  always_comb
  begin
    eventGate = '1;
    for (int c = 0; c < sa_pkg::NUM_COUNTERS; c++)
    begin
      // Expiry cycle already counts as released, else one event is lost
      if (counterEnable[c] && !countersReleased && !counterTimerExpired
          && eventCount[c] <
             counterLimit[c*sa_pkg::COUNT_W +: sa_pkg::COUNT_W])
        eventGate[counterEventSel[c*sa_pkg::EVT_IDX_W +:
                  sa_pkg::EVT_IDX_W]] = 1'b0;
    end
  end

  assign gatedEvent = rawEvent & eventGate;

  // Hidden status: cold reset clears it, a new event beats a clear
  always_ff @(posedge clock)
  begin
    if (rst || coldRst)
      eventStatus <= '0;
    else
      eventStatus <= (eventStatus & ~syndromeClear) | gatedEvent;
  end

  // Visible syndrome survives cold reset for post-mortem reading
  always_ff @(posedge clock)
  begin
    if (rst)
      syndrome <= '0;
    else
      syndrome <= (syndrome & ~syndromeClear) | gatedEvent;
  end

  assign eventSyndromeLow = syndrome[sa_pkg::HALF_EVENTS-1:0];
  assign eventSyndromeHigh =
    syndrome[sa_pkg::NUM_EVENTS-1:sa_pkg::HALF_EVENTS];

  always_ff @(posedge clock)
  begin
    if (rst || coldRst)
      alarmStatus <= '0;
    else
      alarmStatus <= eventStatus;
  end

  // Response routing: OR of every enabled status routed to each action
  always_comb
  begin
    next_responseAction = '0;
    for (int e = 0; e < sa_pkg::NUM_EVENTS; e++)
    begin
      if (eventStatus[e] && routeEnable[e])
        next_responseAction[routeAction[e*sa_pkg::ACT_IDX_W +:
                            sa_pkg::ACT_IDX_W]] = 1'b1;
    end
  end

  // Reset requests are cleared by cold reset directly, along with the status
  always_ff @(posedge clock)
  begin
    if (rst || coldRst)
      responseAction <= '0;
    else
      responseAction <= next_responseAction;
  end

  assign coldResetRequest = responseAction[sa_pkg::COLD_RESET_ACTION];
  assign warmResetRequest = responseAction[sa_pkg::WARM_RESET_ACTION];

  // Configuration-done trigger: one request per reset, held until acked
  always_ff @(posedge clock)
  begin
    if (rst || coldRst)
      cfgState <= sa_pkg::SA_CFG_WAIT;
    else
    begin
      unique case (cfgState)
        sa_pkg::SA_CFG_WAIT:
          if (configProgrammed && sensorsStableSync)
            cfgState <= sa_pkg::SA_CFG_REQ;
        sa_pkg::SA_CFG_REQ:
          if (configDoneAck)
            cfgState <= sa_pkg::SA_CFG_DONE;
        sa_pkg::SA_CFG_DONE:
          cfgState <= sa_pkg::SA_CFG_DONE;
        default:
          cfgState <= sa_pkg::SA_CFG_WAIT;
      endcase
    end
  end

  assign configDoneTrigger = (cfgState == sa_pkg::SA_CFG_REQ);

  // Capture words reload every cycle their event is high
  for (genvar w = 0; w < sa_pkg::CAP_WORDS; w++)
  begin : g_capture
    localparam int EVT = sa_pkg::sa_cap_word_event(w);
    always_ff @(posedge clock)
    begin
      if (rst)
        captureReg[w*sa_pkg::CAP_W +: sa_pkg::CAP_W] <= '0;
      else if (captureEvent[EVT])
        captureReg[w*sa_pkg::CAP_W +: sa_pkg::CAP_W] <=
          captureData[w*sa_pkg::CAP_W +: sa_pkg::CAP_W];
    end
  end

endmodule : sa_alarm_io

// file: sa_alarm_io_chk.sv
// Purpose: Port-level checks for sa_alarm_io
// Assumes: One clock domain, rst disables every check
// Notes: Bound from the bench top file
`timescale 1ns/1ps
module sa_alarm_io_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic cold_reset_n_a,
  input wire logic externalSensorsStable,
  input wire logic configProgrammed,
  input wire logic configDoneAck,
  input wire logic counterTimerLoad,
  input wire logic [31:0] counterTimerInitialValue,
  input wire logic [12:0] captureEvent,
  input wire logic [511:0] captureData,
  input wire logic [63:0] alarmStatus,
  input wire logic [31:0] eventSyndromeLow,
  input wire logic [31:0] eventSyndromeHigh,
  input wire logic [7:0] responseAction,
  input wire logic configDoneTrigger,
  input wire logic [511:0] captureReg,
  input wire logic [31:0] counterTimerValue
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  logic [63:0] syn;
  assign syn = {eventSyndromeHigh, eventSyndromeLow};
  chk_timer_load: assert property (
    counterTimerLoad && cold_reset_n_a |=>
    counterTimerValue == $past(counterTimerInitialValue)) else $error("load");
  chk_timer_step: assert property (
    counterTimerValue != 32'h0 && !counterTimerLoad && cold_reset_n_a |=>
    counterTimerValue == $past(counterTimerValue) - 32'h1) else $error("step");
  // Hidden status may never hold a bit the syndrome lacks
  chk_status_syn: assert property (
    (alarmStatus & ~$past(syn)) == 64'h0) else $error("status");
  chk_cfg_gate: assert property (
    $rose(configDoneTrigger) |-> $past(configProgrammed) &&
    $past(externalSensorsStable, 3)) else $error("cfg gate");
  chk_cfg_ack: assert property (
    configDoneTrigger && cold_reset_n_a |=>
    configDoneTrigger == !$past(configDoneAck)) else $error("cfg ack");
  chk_cap_load: assert property (
    captureEvent[4] |=> captureReg[255:128] ==
    $past(captureData[255:128])) else $error("capture load");
  chk_cap_keep: assert property (
    !captureEvent[0] |=> $stable(captureReg[31:0])) else $error("capture");
  chk_cold_clear: assert property (
    !cold_reset_n_a |=> alarmStatus == 64'h0 && responseAction == 8'h0)
    else $error("cold clear");
endmodule : sa_alarm_io_chk

// file: sa_sensor_model.sv
// Purpose: Far side: sensors, stable flag, config-done consumer
// Assumes: Drives on falling edges of clock
// Notes: Ack waits three cycles to act as a slow consumer
`timescale 1ns/1ps
module sa_sensor_model (
  input wire logic clock,
  input wire logic configDoneTrigger,
  output logic [60:0] alarmIn,
  output logic externalSensorsStable,
  output logic configDoneAck
);
  int waitCnt = 0;
  assign configDoneAck = waitCnt == 3;
  always @(negedge clock)
    waitCnt <= configDoneTrigger ? waitCnt + 1 : 0;
  initial
  begin
    alarmIn = '0;
    externalSensorsStable = 1'h0;
    // Sensors settle well after reset release
    repeat (30) @(negedge clock);
    externalSensorsStable = 1'h1;
  end
  task automatic pulse(input int idx);
    @(negedge clock);
    alarmIn[idx] = 1'h1;
    repeat (2) @(negedge clock);
    alarmIn[idx] = 1'h0;
  endtask : pulse
endmodule : sa_sensor_model

// file: tb_top.sv
// Purpose: Self-checking bench for sa_alarm_io
// Assumes: Far-side model acks the config-done trigger
// Notes: Expected images are kept by the bench model
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic cold_reset_n_a = 1'h1;
  logic [2:0] internalEvent = '0;
  logic configProgrammed = 1'h0;
  logic [63:0] syndromeClear = '0;
  logic [63:0] routeEnable = '0;
  logic [191:0] routeAction = '0;
  logic [31:0] counterTimerInitialValue = '0;
  logic counterTimerLoad = 1'h0;
  logic [3:0] counterEnable = '0;
  logic [23:0] counterEventSel = '0;
  logic [31:0] counterLimit = '0;
  logic [12:0] captureEvent = '0;
  logic [511:0] captureData = '0;
  logic [60:0] alarmIn;
  logic externalSensorsStable, configDoneAck, configDoneTrigger;
  logic [63:0] alarmStatus, expSyn, expStat;
  logic [31:0] eventSyndromeLow, eventSyndromeHigh, counterTimerValue, r;
  logic [7:0] responseAction;
  logic coldResetRequest, warmResetRequest, counterTimerExpired;
  logic [511:0] captureReg, expCap;
  logic [15:0] seed = 16'h42F8;
  int errors = 0;
  int totalChecks = 0;
  int n, idx;
  sa_alarm_io u_sa_alarm_io (.*);
  sa_sensor_model u_sa_sensor_model (
    .clock(clock),
    .configDoneTrigger(configDoneTrigger),
    .alarmIn(alarmIn),
    .externalSensorsStable(externalSensorsStable),
    .configDoneAck(configDoneAck)
  );
  initial forever #5 clock = ~clock;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic rnd(output logic [31:0] v);
    seed = lfsr(seed);
    v[15:0] = seed;
    seed = lfsr(seed);
    v[31:16] = seed;
  endtask : rnd
  task automatic cmpVal(input string nm, input logic [511:0] e, g);
    totalChecks++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s exp %h got %h", nm, e, g);
    end
  endtask : cmpVal
  task automatic cmpFlag(input string nm, input logic e, g);
    totalChecks++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s exp %b got %b", nm, e, g);
    end
  endtask : cmpFlag
  task automatic stopTest();
    $display("checks %0d errors %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stopTest
  task automatic checkAll();
    logic [7:0] act;
    act = '0;
    for (int e = 0; e < 64; e++)
      if (expStat[e] && routeEnable[e])
        act[routeAction[3*e +: 3]] = 1'h1;
    cmpVal("syndrome", expSyn, {eventSyndromeHigh, eventSyndromeLow});
    cmpVal("status", expStat, alarmStatus);
    cmpVal("action", act, responseAction);
    cmpFlag("coldReq", act[0], coldResetRequest);
    cmpFlag("warmReq", act[1], warmResetRequest);
    cmpVal("capture", expCap, captureReg);
  endtask : checkAll
  task automatic porReset();
    @(negedge clock);
    rst = 1'h1;
    repeat (4) @(negedge clock);
    rst = 1'h0;
    expSyn = '0;
    expStat = '0;
    expCap = '0;
    checkAll();
  endtask : porReset
  task automatic pulseInt(input int b);
    internalEvent[b] = 1'h1;
    @(negedge clock);
    internalEvent[b] = 1'h0;
    repeat (3) @(negedge clock);
  endtask : pulseInt
  initial
  begin
    porReset();
    repeat (40) @(negedge clock);
    cmpFlag("cfgDone", 1'h0, configDoneTrigger);
    configProgrammed = 1'h1;
    repeat (3) @(negedge clock);
    cmpFlag("cfgDone", 1'h1, configDoneTrigger);
    repeat (3) @(negedge clock);
    cmpFlag("cfgDone", 1'h0, configDoneTrigger);
    for (int i = 0; i < 8; i++)
    begin
      rnd(r);
      routeAction[24*i +: 24] = r[23:0];
    end
    rnd(routeEnable[31:0]);
    rnd(routeEnable[63:32]);
    pulseInt(0);
    expSyn[0] = 1'h1;
    expStat[0] = 1'h1;
    for (int i = 0; i < 8; i++)
    begin
      rnd(r);
      idx = int'(r % 61);
      u_sa_sensor_model.pulse(idx);
      repeat (4) @(negedge clock);
      expSyn[3 + idx] = 1'h1;
      expStat[3 + idx] = 1'h1;
      checkAll();
    end
    for (int k = 0; k < 13; k++)
    begin
      for (int w = 0; w < 16; w++)
        rnd(captureData[32*w +: 32]);
      captureEvent[k] = 1'h1;
      @(negedge clock);
      captureEvent[k] = 1'h0;
      n = k < 5 ? k : k + 3;
      idx = k == 4 ? 7 : n;
      for (int w = n; w <= idx; w++)
        expCap[32*w +: 32] = captureData[32*w +: 32];
      expSyn[14 + k] = 1'h1;
      expStat[14 + k] = 1'h1;
      repeat (3) @(negedge clock);
      checkAll();
    end
    counterEnable = 4'h3;
    counterEventSel = {12'h000, 6'h01, 6'h02};
    counterLimit = 32'h0000_0303;
    for (int t = 0; t < 2; t++)
    begin
      rnd(r);
      n = t == 0 ? 200 : 3 + int'(r % 20);
      counterTimerInitialValue = 32'(n);
      counterTimerLoad = 1'h1;
      @(negedge clock);
      counterTimerLoad = 1'h0;
      // Fourth occurrence is the first to pass a limit of three
      for (int p = 0; p < 4 && t == 0; p++)
      begin
        pulseInt(2);
        expSyn[2] = p == 3;
        expStat[2] = p == 3;
        checkAll();
      end
    end
    idx = 0;
    while (counterTimerExpired !== 1'h1 && idx < 1000)
    begin
      @(posedge clock);
      #1;
      idx++;
    end
    cmpVal("expiry", n + 1, idx);
    if (idx < 1000)
    begin
      @(negedge clock);
      pulseInt(1);
      expSyn[1] = 1'h1;
      expStat[1] = 1'h1;
      checkAll();
      // Software acknowledge drops both status copies of event 0
      syndromeClear[0] = 1'h1;
      @(negedge clock);
      syndromeClear[0] = 1'h0;
      repeat (2) @(negedge clock);
      expSyn[0] = 1'h0;
      expStat[0] = 1'h0;
      checkAll();
      cold_reset_n_a = 1'h0;
      repeat (2) @(negedge clock);
      cold_reset_n_a = 1'h1;
      expStat = '0;
      checkAll();
      porReset();
    end
    stopTest();
  end
endmodule : tb_top
bind sa_alarm_io sa_alarm_io_chk u_sa_alarm_io_chk (.*);
